// ===== core/light_sensor_defs.vh
// Constants shared by the light sensor serial target port.
`ifndef LIGHT_SENSOR_DEFS_VH
`define LIGHT_SENSOR_DEFS_VH

// Target addresses chosen by the strap pin.
`define ADDR_STRAP_GND 7'h44
`define ADDR_STRAP_VDD 7'h45
`define ADDR_STRAP_SDA 7'h46
`define ADDR_STRAP_SCL 7'h47

// Strap pin encodings.
`define STRAP_GND 2'h0
`define STRAP_VDD 2'h1
`define STRAP_SDA 2'h2
`define STRAP_SCL 2'h3

// High-speed entry code: upper five bits of the first byte.
`define HS_CODE_TOP 5'h01

// Stuck-low timeout.
`define TIMEOUT_US 28000
`define CLK_PERIOD_NS 8
`define TIMEOUT_CYC (`TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

// Range_linear_value width against conversion time setting.
`define MANT_W 20
`define MANT_MIN_BITS 9
`define MANT_PAD_MAX 5'hB
`define CONV_TIME_MAX 4'hB

// Reset value of the register pointer.
`define PTR_RESET 8'h00

// Write FIFO shape.
`define WFIFO_DEPTH 16
`define WFIFO_AW 4

`endif

// ===== core/light_sensor_i2c_target_port.v
// Serial target port of a colour light sensor, with its write FIFO.
//
// Contract
// - Range_linear_value keeps 9 bits at setting 0, one more per step to 20.
// - Port works at standard, fast and high-speed bus rates.
// - SDA change while SCL high is a start (fall) or stop (rise).
// - After start shift in seven address bits then the read/write bit.
// - On own address, pull SDA low during the ninth clock.
// - Eight bits then acknowledge, most significant first, SDA stable on high.
// - SCL low for 28 ms resets the bus state machine.
// - Strap selects one of four seven-bit addresses.
// - Strap sampled at every transaction; must be settled beforehand.
// - First byte after a write address loads the register pointer.
// - Next two bytes, high first, write the pointed register; the high byte is always acked, the low byte unless the write FIFO is full.
// - A read sends the pointed register high byte, then low byte.
// - Release SDA on controller not-acknowledge, start or stop.
// - Pointer is kept across transactions until a new pointer write.
// - High-speed code is recognised without ack; stop leaves high speed.
`timescale 1ns/1ps
`include "light_sensor_defs.vh"

module write_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = `WFIFO_DEPTH,
  parameter AW = `WFIFO_AW
) (
  input wire clk_sys,
  input wire rst_n,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] count;
  wire do_w;
  wire do_r;
  wire [AW:0] next_count;

  // The output stage is a register so the block outputs stay flopped.
  assign do_w = in_valid & in_ready;
  assign do_r = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);
  assign next_count = count + {{AW{1'b0}}, do_w} - {{AW{1'b0}}, do_r};

  always @(posedge clk_sys) begin
    if (do_w) begin
      mem[wp] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (do_w) begin
        wp <= wp + 1'b1;
      end
      if (do_r) begin
        out_data <= mem[rp];
        out_valid <= 1'b1;
        rp <= rp + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= next_count;
      in_ready <= (next_count < DEPTH);
    end
  end
endmodule

module light_sensor_i2c_target_port #(
  parameter TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [1:0] addr_sel,
  output reg [7:0] reg_ptr,
  input wire [15:0] rd_data,
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_ptr,
  output wire [15:0] wr_data,
  output reg hs_mode,
  input wire [3:0] conv_time,
  input wire [19:0] mant_raw,
  output reg [19:0] range_linear_value
);
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_PTR = 4'h2;
  localparam ST_WDAT = 4'h3;
  localparam ST_ACK = 4'h4;
  localparam ST_RD = 4'h5;
  localparam ST_RACK = 4'h6;
  localparam ST_IGNORE = 4'h7;

  reg [3:0] state;
  reg [3:0] after_ack;
  reg scl_r;
  reg sda_r;
  reg scl_p;
  reg sda_p;
  reg [2:0] bit_cnt;
  reg got_byte;
  reg [7:0] rx_sr;
  reg [7:0] tx_sr;
  reg [15:0] tx_word;
  reg tx_lo;
  reg wr_lo;
  reg [7:0] data_hi;
  reg ctl_ack;
  reg [6:0] own_addr;
  reg [21:0] low_cnt;
  reg push;
  reg [23:0] push_word;
  wire push_ready;
  wire [23:0] fifo_out;
  wire start_cond;
  wire stop_cond;
  wire scl_rise;
  wire scl_fall;
  wire timed_out;

  function [6:0] strap_addr;
    input [1:0] sel;
    begin
      case (sel)
        `STRAP_GND: strap_addr = `ADDR_STRAP_GND;
        `STRAP_VDD: strap_addr = `ADDR_STRAP_VDD;
        `STRAP_SDA: strap_addr = `ADDR_STRAP_SDA;
        default: strap_addr = `ADDR_STRAP_SCL;
      endcase
    end
  endfunction

  // Low bits beyond the effective width read as zero.
  function [19:0] pad_mant;
    input [19:0] raw;
    input [3:0] ct;
    reg [3:0] c;
    reg [4:0] zeros;
    begin
      c = (ct > `CONV_TIME_MAX) ? `CONV_TIME_MAX : ct;
      zeros = `MANT_PAD_MAX - {1'b0, c};
      pad_mant = raw & (20'hFFFFF << zeros);
    end
  endfunction

  assign start_cond = scl_r & scl_p & sda_p & ~sda_r;
  assign stop_cond = scl_r & scl_p & ~sda_p & sda_r;
  assign scl_rise = scl_r & ~scl_p;
  assign scl_fall = ~scl_r & scl_p;
  assign timed_out = (low_cnt == TIMEOUT_CYCLES[21:0] - 22'h1);

  write_fifo #(
    .WIDTH(24),
    .DEPTH(`WFIFO_DEPTH),
    .AW(`WFIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  assign wr_ptr = fifo_out[23:16];
  assign wr_data = fifo_out[15:0];

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      range_linear_value <= 20'h00000;
    end else begin
      range_linear_value <= pad_mant(mant_raw, conv_time);
    end
  end

  // Only SCL held low inside a transaction counts toward the timeout.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      low_cnt <= 22'h0;
    end else if (scl_r || state == ST_IDLE || timed_out) begin
      low_cnt <= 22'h0;
    end else begin
      low_cnt <= low_cnt + 22'h1;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      bit_cnt <= 3'h0;
      got_byte <= 1'b0;
      rx_sr <= 8'h00;
      tx_sr <= 8'h00;
      tx_word <= 16'h0000;
      tx_lo <= 1'b0;
      wr_lo <= 1'b0;
      data_hi <= 8'h00;
      ctl_ack <= 1'b0;
      own_addr <= `ADDR_STRAP_GND;
      reg_ptr <= `PTR_RESET;
      push <= 1'b0;
      push_word <= 24'h000000;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      hs_mode <= 1'b0;
    end else begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      scl_p <= scl_r;
      sda_p <= sda_r;
      push <= 1'b0;
      if (timed_out) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        // A repeated start keeps high speed; only a stop drops it.
        state <= ST_ADDR;
        bit_cnt <= 3'h0;
        got_byte <= 1'b0;
        sda_oe <= 1'b0;
        own_addr <= strap_addr(addr_sel);
      end else if (stop_cond) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
        hs_mode <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            if (scl_rise) begin
              rx_sr <= {rx_sr[6:0], sda_r};
              bit_cnt <= bit_cnt + 3'h1;
              got_byte <= (bit_cnt == 3'h7);
            end else if (scl_fall && got_byte) begin
              got_byte <= 1'b0;
              state <= ST_ACK;
              sda_oe <= 1'b1;
              case (state)
                ST_ADDR: begin
                  if (rx_sr[7:1] == own_addr) begin
                    after_ack <= rx_sr[0] ? ST_RD : ST_PTR;
                    tx_word <= rd_data;
                  end else begin
                    sda_oe <= 1'b0;
                    state <= ST_IGNORE;
                    if (rx_sr[7:3] == `HS_CODE_TOP) begin
                      hs_mode <= 1'b1;
                    end
                  end
                end
                ST_PTR: begin
                  reg_ptr <= rx_sr;
                  wr_lo <= 1'b0;
                  after_ack <= ST_WDAT;
                end
                default: begin
                  after_ack <= ST_WDAT;
                  if (!wr_lo) begin
                    data_hi <= rx_sr;
                    wr_lo <= 1'b1;
                  end else if (push_ready) begin
                    push <= 1'b1;
                    push_word <= {reg_ptr, data_hi, rx_sr};
                    wr_lo <= 1'b0;
                  end else begin
                    // A full FIFO refuses the word with a not-acknowledge.
                    sda_oe <= 1'b0;
                    state <= ST_IGNORE;
                  end
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              state <= after_ack;
              if (after_ack == ST_RD) begin
                tx_sr <= tx_word[15:8];
                tx_lo <= 1'b1;
                sda_oe <= ~tx_word[15];
              end else begin
                sda_oe <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                sda_oe <= 1'b0;
                state <= ST_RACK;
              end else begin
                sda_oe <= ~tx_sr[6];
                tx_sr <= {tx_sr[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ctl_ack <= ~sda_r;
            end else if (scl_fall) begin
              if (ctl_ack) begin
                // Past the low byte the same register is sent again.
                tx_sr <= tx_lo ? tx_word[7:0] : tx_word[15:8];
                sda_oe <= tx_lo ? ~tx_word[7] : ~tx_word[15];
                tx_lo <= ~tx_lo;
                bit_cnt <= 3'h0;
                state <= ST_RD;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            sda_oe <= 1'b0;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== verification/sensor_port_props_properties.sv
// Concurrent checks on the light sensor serial target port.
`timescale 1ns/1ps
module sensor_port_props #(
  parameter TIMEOUT_CYCLES = 3500000
) (
  input wire clk_sys,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [1:0] addr_sel,
  input wire [7:0] reg_ptr,
  input wire [15:0] rd_data,
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_ptr,
  input wire [15:0] wr_data,
  input wire hs_mode,
  input wire [3:0] conv_time,
  input wire [19:0] mant_raw,
  input wire [19:0] range_linear_value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  int low_run;
  always @(posedge clk_sys) begin
    if (!rst_n || scl_in)
      low_run <= 0;
    else if (low_run < TIMEOUT_CYCLES + 100)
      low_run <= low_run + 1;
  end
  function automatic [19:0] keep(input [19:0] raw, input [3:0] ct);
    keep = raw & ~((20'h1 << (4'hB - (ct > 4'hB ? 4'hB : ct))) - 20'h1);
  endfunction
  sequence stop_seen;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence released;
    !sda_oe && !hs_mode;
  endsequence
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data output not zero");
  mant_mask_a: assert property ($past(rst_n) |->
    range_linear_value == keep($past(mant_raw), $past(conv_time)))
    else $error("range_linear_value padding wrong");
  ptr_reset_a: assert property ($rose(rst_n) |-> reg_ptr == 8'h00)
    else $error("pointer not cleared");
  oe_on_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  ptr_on_low_a: assert property ($changed(reg_ptr) |-> !scl_in)
    else $error("pointer moved while clock high");
  wr_hold_a: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_data) && $stable(wr_ptr))
    else $error("written word not held");
  stop_release_a: assert property (stop_seen |-> ##[1:4] released)
    else $error("stop did not release");
  hs_noack_a: assert property ($rose(hs_mode) |-> !sda_oe [*4])
    else $error("fast code acknowledged");
  timeout_a: assert property (low_run == TIMEOUT_CYCLES + 8 |-> !sda_oe)
    else $error("stuck clock not released");
endmodule
bind light_sensor_i2c_target_port sensor_port_props #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk (.clk_sys, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_sel,
  .reg_ptr, .rd_data, .wr_valid, .wr_ready, .wr_ptr, .wr_data, .hs_mode,
  .conv_time, .mant_raw, .range_linear_value);

// ===== verification/bus_ctrl_model.sv
// Bus controller model: makes the clock, starts, stops and bit slots.
`timescale 1ns/1ps
module bus_ctrl_model (
  input wire clk_sys,
  input wire sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Data moves only while the clock is low, so no slot fakes a condition.
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sda_drv <= b;
    tick(3);
    scl <= 1'b1;
    tick(4);
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start;
    tick(1);
    sda_drv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b0;
    tick(4);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tick(1);
    sda_drv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(4);
    sda_drv <= 1'b1;
    tick(4);
  endtask
  task automatic wb(input [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rb(input logic nak, output [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(nak, r);
  endtask
endmodule

// ===== verification/light_sensor_i2c_target_port_bench.sv
// Self-checking bench for the light sensor serial target port.
`timescale 1ns/1ps
`define CMP(g, e, m) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: %s", $time, m); \
  end \
end
module light_sensor_i2c_target_port_bench;
  localparam int TO = 200;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] addr_sel = 2'h0;
  logic [15:0] rd_data = 16'hA55A;
  logic wr_ready = 1'b0;
  logic [3:0] conv_time = 4'h0;
  logic [19:0] mant_raw = 20'hFFFFF;
  wire scl, sda_drv, sda_oe, sda_out, wr_valid, hs_mode;
  wire [7:0] reg_ptr, wr_ptr;
  wire [15:0] wr_data;
  wire [19:0] range_linear_value;
  wire sda = sda_drv & ~sda_oe;
  int miscompares = 0;
  int checks_done = 0;
  int n;
  logic a;
  logic [7:0] d;
  logic [23:0] rows [13] = '{24'h0FF800, 24'h1FFC00, 24'h2FFE00,
    24'h3FFF00, 24'h4FFF80, 24'h5FFFC0, 24'h6FFFE0, 24'h7FFFF0,
    24'h8FFFF8, 24'h9FFFFC, 24'hAFFFFE, 24'hBFFFFF, 24'hFFFFFF};
  always #4 clk_sys = ~clk_sys;
  bus_ctrl_model ctl (.clk_sys, .sda, .scl, .sda_drv);
  light_sensor_i2c_target_port #(.TIMEOUT_CYCLES(TO)) dut (.clk_sys,
    .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_sel,
    .reg_ptr, .rd_data, .wr_valid, .wr_ready, .wr_ptr, .wr_data,
    .hs_mode, .conv_time, .mant_raw, .range_linear_value);
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input [7:0] b, input logic e);
    ctl.wb(b, a);
    `CMP(a, e, "acknowledge")
  endtask
  initial begin
    #320000;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CMP(reg_ptr, 8'h00, "pointer after reset")
    foreach (rows[i]) begin
      conv_time <= rows[i][23:20];
      repeat (2) @(posedge clk_sys);
      `CMP(range_linear_value, rows[i][19:0], "range_linear_value")
    end
    for (int s = 0; s < 4; s++) begin
      addr_sel <= s[1:0];
      ctl.start;
      wr({5'h11, s[1:0] + 2'h1, 1'b0}, 1'b0);
      ctl.stop;
      ctl.start;
      wr({5'h11, s[1:0], 1'b0}, 1'b1);
      wr(8'h30 + s[7:0], 1'b1);
      ctl.stop;
      `CMP(reg_ptr, 8'h30 + s[7:0], "pointer")
    end
    ctl.start;
    wr(8'h8E, 1'b1);
    wr(8'h0A, 1'b1);
    wr(8'h12, 1'b1);
    wr(8'h34, 1'b1);
    ctl.stop;
    `CMP({wr_valid, wr_ptr, wr_data}, 25'h10A1234, "word")
    wr_ready <= 1'b1;
    @(posedge clk_sys);
    wr_ready <= 1'b0;
    @(posedge clk_sys);
    `CMP(wr_valid, 1'b0, "word taken")
    ctl.start;
    wr(8'h8F, 1'b1);
    ctl.rb(1'b0, d);
    `CMP(d, 8'hA5, "upper byte")
    ctl.rb(1'b1, d);
    `CMP(d, 8'h5A, "lower byte")
    ctl.stop;
    `CMP(sda_oe, 1'b0, "released")
    `CMP(reg_ptr, 8'h0A, "pointer kept")
    ctl.start;
    wr(8'h08, 1'b0);
    `CMP(hs_mode, 1'b1, "fast mode")
    ctl.stop;
    `CMP(hs_mode, 1'b0, "fast mode left")
    ctl.start;
    wr(8'h8E, 1'b1);
    wr(8'h20, 1'b1);
    n = 0;
    for (int i = 0; i < 18; i++) begin
      ctl.wb(8'h00, a);
      ctl.wb(i[7:0], a);
      n += a;
    end
    ctl.stop;
    `CMP(n, 17, "words accepted")
    wr_ready <= 1'b1;
    n = 0;
    // Sampled between edges so the count never races the FIFO update.
    repeat (80) begin
      @(negedge clk_sys);
      if (wr_valid === 1'b1)
        n++;
    end
    `CMP(n, 17, "words drained")
    ctl.start;
    d = 8'h8E;
    for (int i = 7; i >= 0; i--)
      ctl.bitx(d[i], a);
    repeat (4) @(posedge clk_sys);
    `CMP(sda_oe, 1'b1, "address acknowledge")
    repeat (TO + 20) @(posedge clk_sys);
    `CMP(sda_oe, 1'b0, "stuck clock release")
    ctl.stop;
    tally_and_finish;
  end
endmodule
